// File: dv/ctx_seq_model.sv
// stand-in for the context save/restore sequencer feeding the trap detector
// assumes the bench changes i_cmd shortly after a rising edge and holds it one cycle
`timescale 1ns/1ns
module ctx_seq_model (
	input wire logic [2:0] i_cmd, // 0 idle 1 save 2 save at limit 3 save empty 4 restore 5 restore null
	output logic o_save_req, // save attempted
	output logic o_save_done, // save completed
	output logic o_restore_req, // restore attempted
	output logic [31:0] o_save_area, // area used by the save
	output logic [31:0] o_limit_ptr, // limit pointer
	output logic [31:0] o_free_head, // free list head
	output logic [31:0] o_prev_ptr // previous context pointer
);
	// ==========================================
	// sequencer outputs
	// limit sits two areas short of the list end, so a depletion never runs dry
	assign o_limit_ptr = 32'h0000_0400;
	assign o_save_req = i_cmd inside {3'h1, 3'h2, 3'h3};
	assign o_save_done = i_cmd inside {3'h1, 3'h2};
	assign o_save_area = (i_cmd == 3'h2) ? o_limit_ptr : 32'h0000_0440;
	assign o_free_head = (i_cmd == 3'h3) ? 32'h0000_0000 : 32'h0000_0480;
	assign o_restore_req = i_cmd inside {3'h4, 3'h5};
	assign o_prev_ptr = (i_cmd == 3'h5) ? 32'h0000_0000 : 32'h0000_0500;
endmodule

// File: dv/tb_trap_detect.sv
// self-checking bench for the trap detector
// assumes one-cycle registered latency from cause to trap outputs
`timescale 1ns/1ns
module tb_trap_detect;
	logic i_sys_clk, i_rst, i_valid, i_user0, i_mem_op, i_seg_periph, i_base_offset, i_misaligned, i_circ_bad;
	logic i_csfr_addr, i_csa_bad_place, i_scratch_oor, i_gw_write, i_gw_perm, i_opc_unknown, i_opc_unimpl;
	logic i_opd_odd_pair, i_opd_check_en, i_call, i_ret, i_rfe, i_cd_en, i_save_in_entry, i_ctx_err;
	logic i_restore_upper, i_saved_kind, i_dsf_clear, i_save_req, i_save_done, i_restore_req;
	logic [31:0] i_ea, i_base, i_save_area, i_limit_ptr, i_free_head, i_prev_ptr, i_handler_pc, i_next_pc;
	logic [31:0] i_vec_base, o_entry_addr, o_ret_addr;
	logic [3:0] i_acc_bytes;
	logic [6:0] i_cd_count, i_cd_max;
	logic [2:0] cmd, o_trap_class_index;
	logic [7:0] o_trap_ident_number, o_cand_prot, o_cand_instr, o_cand_ctx;
	logic o_trap_valid, o_depletion_status_flag, o_ctx_abandon;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	// ==========================================
	// design and sequencer
	trap_detect DUT (.i_sys_clk, .i_rst, .i_valid, .i_user0, .i_mem_op, .i_seg_periph, .i_ea, .i_base,
		.i_base_offset, .i_acc_bytes, .i_misaligned, .i_circ_bad, .i_csfr_addr, .i_csa_bad_place,
		.i_scratch_oor, .i_gw_write, .i_gw_perm, .i_opc_unknown, .i_opc_unimpl, .i_opd_odd_pair,
		.i_opd_check_en, .i_call, .i_ret, .i_rfe, .i_cd_en, .i_cd_count, .i_cd_max, .i_save_req,
		.i_save_done, .i_save_in_entry, .i_save_area, .i_limit_ptr, .i_free_head, .i_ctx_err,
		.i_restore_req, .i_restore_upper, .i_prev_ptr, .i_saved_kind, .i_handler_pc, .i_next_pc,
		.i_vec_base, .i_dsf_clear, .o_trap_valid, .o_trap_class_index, .o_trap_ident_number,
		.o_entry_addr, .o_cand_prot, .o_cand_instr, .o_cand_ctx, .o_depletion_status_flag,
		.o_ret_addr, .o_ctx_abandon);
	ctx_seq_model seq (.i_cmd(cmd), .o_save_req(i_save_req), .o_save_done(i_save_done),
		.o_restore_req(i_restore_req), .o_save_area(i_save_area), .o_limit_ptr(i_limit_ptr),
		.o_free_head(i_free_head), .o_prev_ptr(i_prev_ptr));
	// ==========================================
	// clock and hang guard
	initial begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 500) begin
			num_errors++;
			tally_and_finish;
		end
	end
	// ==========================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic idle;
		{i_valid, i_user0, i_mem_op, i_seg_periph, i_base_offset, i_misaligned, i_circ_bad} = '0;
		{i_csfr_addr, i_csa_bad_place, i_scratch_oor, i_gw_write, i_opc_unknown, i_opc_unimpl} = '0;
		{i_opd_odd_pair, i_call, i_ret, i_rfe, i_save_in_entry, i_ctx_err, i_dsf_clear} = '0;
		{i_restore_upper, i_saved_kind, i_gw_perm, i_opd_check_en, i_cd_en} = 5'b0_0111;
		i_ea = 32'h2000_0010;
		i_base = 32'h2000_0000;
		i_acc_bytes = 4'h4;
		i_cd_count = 7'h05;
		i_cd_max = 7'h40;
		i_handler_pc = 32'h8000_2000;
		i_next_pc = 32'h8000_3000;
		i_vec_base = 32'h8000_0100;
		cmd = 3'h0;
	endtask
	task automatic step;
		@(posedge i_sys_clk);
		#10;
	endtask
	// class 0 means no trap is expected
	task automatic expect_trap(input logic [2:0] c, input logic [7:0] t);
		step;
		check(o_trap_valid, c != 3'h0);
		if (c != 3'h0) begin
			check(o_trap_class_index, c);
			check(o_trap_ident_number, t);
			check(o_entry_addr, i_vec_base | (32'(c) << 5));
			check(({o_cand_ctx, o_cand_instr, o_cand_prot} >> ((c - 1) * 8 + t)) & 24'h1, 1);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		idle;
		i_rst = 1'b1;
		repeat (20) @(posedge i_sys_clk);
		#10 i_rst = 1'b0;
		expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_mem_op = 1; i_ea = '0; expect_trap(3'h1, 8'h6);
		idle; i_valid = 1; i_mem_op = 1; i_user0 = 1; i_seg_periph = 1; expect_trap(3'h1, 8'h5);
		idle; i_valid = 1; i_mem_op = 1; i_seg_periph = 1; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_gw_write = 1; i_gw_perm = 0; expect_trap(3'h1, 8'h7);
		idle; i_valid = 1; i_gw_write = 1; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_opc_unknown = 1; expect_trap(3'h2, 8'h1);
		idle; i_valid = 1; i_opc_unimpl = 1; expect_trap(3'h2, 8'h2);
		idle; i_valid = 1; i_opd_odd_pair = 1; expect_trap(3'h2, 8'h3);
		idle; i_valid = 1; i_opd_odd_pair = 1; i_opd_check_en = 0; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_mem_op = 1; i_misaligned = 1; expect_trap(3'h2, 8'h4);
		idle; i_valid = 1; i_mem_op = 1; i_circ_bad = 1; expect_trap(3'h2, 8'h4);
		idle; i_valid = 1; i_mem_op = 1; i_base_offset = 1; i_base = 32'h1000_0000; expect_trap(3'h2, 8'h5);
		idle; i_valid = 1; i_mem_op = 1; i_ea = 32'h1FFF_FFFE; expect_trap(3'h2, 8'h5);
		idle; i_valid = 1; i_mem_op = 1; i_ea = 32'h1FFF_FFFC; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_mem_op = 1; i_csfr_addr = 1; expect_trap(3'h2, 8'h5);
		idle; i_valid = 1; i_mem_op = 1; i_scratch_oor = 1; expect_trap(3'h2, 8'h5);
		idle; i_valid = 1; i_mem_op = 1; i_csa_bad_place = 1; expect_trap(3'h2, 8'h5);
		idle; cmd = 3'h2; i_save_in_entry = 1; expect_trap(3'h3, 8'h1);
		check(o_ret_addr, i_handler_pc);
		check(o_depletion_status_flag, 1);
		idle; expect_trap(3'h0, 8'h0);
		check(o_depletion_status_flag, 1);
		idle; i_dsf_clear = 1; step;
		check(o_depletion_status_flag, 0);
		// depletion outside an entry sequence, with a clear in the same cycle: set must win
		idle; cmd = 3'h2; i_dsf_clear = 1; expect_trap(3'h3, 8'h1);
		check(o_ret_addr, i_next_pc);
		check(o_depletion_status_flag, 1);
		// mid-run reset must drop the sticky flag and the trap valid output
		idle; i_rst = 1'b1; step;
		i_rst = 1'b0;
		check(o_depletion_status_flag, 0);
		check(o_trap_valid, 0);
		idle; i_valid = 1; i_call = 1; i_cd_count = 7'h40; expect_trap(3'h3, 8'h2);
		idle; i_valid = 1; i_call = 1; i_cd_count = 7'h3F; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_ret = 1; i_cd_count = 7'h00; expect_trap(3'h3, 8'h3);
		idle; cmd = 3'h3; expect_trap(3'h3, 8'h4);
		check(o_ctx_abandon, 1);
		idle; cmd = 3'h4; i_ctx_err = 1; expect_trap(3'h3, 8'h4);
		idle; cmd = 3'h5; expect_trap(3'h3, 8'h5);
		idle; cmd = 3'h4; i_restore_upper = 1; expect_trap(3'h3, 8'h6);
		idle; cmd = 3'h4; i_saved_kind = 1; expect_trap(3'h3, 8'h6);
		idle; i_valid = 1; i_rfe = 1; expect_trap(3'h3, 8'h7);
		idle; i_valid = 1; i_rfe = 1; i_cd_count = 7'h00; expect_trap(3'h0, 8'h0);
		idle; i_valid = 1; i_mem_op = 1; i_ea = '0; i_opc_unknown = 1; expect_trap(3'h2, 8'h1);
		check(o_cand_prot[6], 1);
		idle;
		step;
		tally_and_finish;
	end
endmodule

// File: pkg/trap_depth_if.sv
// call depth check signals between the detector and its depth checker
// assumes combinational use inside one clock domain
`timescale 1ns/1ns
interface trap_depth_if;
	logic is_call;
	logic is_ret;
	logic is_rfe;
	logic enable;
	logic [trap_detect_pkg::CDC_W-1:0] count;
	logic [trap_detect_pkg::CDC_W-1:0] max;
	logic overflow;
	logic underflow;
	logic exception_return_depth_trap;
	modport chk (input is_call, is_ret, is_rfe, enable, count, max, output overflow, underflow, exception_return_depth_trap);
	modport top (output is_call, is_ret, is_rfe, enable, count, max, input overflow, underflow, exception_return_depth_trap);
endinterface

// File: pkg/trap_detect_pkg.sv
// constants and state type for the trap detection block
// assumes a single core clock; trap class/ident widths fixed
package trap_detect_pkg;
	localparam int CLS_W = 3;
	localparam int TIN_W = 8;
	localparam int ADDR_W = 32;
	localparam int CDC_W = 7;
	localparam int TCN_SHIFT = 5;
	// trap classes
	localparam logic [2:0] CLS_PROT = 3'h1;
	localparam logic [2:0] CLS_INSTR = 3'h2;
	localparam logic [2:0] CLS_CTX = 3'h3;
	// protection class idents
	localparam int TIN_PERIPH = 5;
	localparam int TIN_NULL = 6;
	localparam int TIN_GLOBAL = 7;
	// instruction error idents
	localparam int TIN_ILLEGAL = 1;
	localparam int TIN_UNIMPL = 2;
	localparam int TIN_OPERAND = 3;
	localparam int TIN_ALIGN = 4;
	localparam int TIN_MEMADDR = 5;
	// context class idents
	localparam int TIN_DEPLETE = 1;
	localparam int TIN_CDO = 2;
	localparam int TIN_CDU = 3;
	localparam int TIN_FREE_UNDER = 4;
	localparam int TIN_STACK_EMPTY = 5;
	localparam int TIN_CTX_KIND = 6;
	localparam int TIN_EXCEPTION_RETURN_DEPTH_TRAP = 7;
	localparam logic [3:0] SEG_MSB_W = 4'h4;

	typedef struct packed {
		logic valid;
		logic [CLS_W-1:0] cls;
		logic [TIN_W-1:0] trap_ident_number;
		logic [ADDR_W-1:0] entry;
		logic [7:0] prot;
		logic [7:0] instr;
		logic [7:0] ctx;
		logic dsf;
		logic [ADDR_W-1:0] ret_addr;
		logic abandon;
	} state_type;
endpackage

// File: rtl/trap_depth_check.sv
// call depth counter checks for call, return and exception return
// assumes the pipeline presents count and maximum for the current instruction
`timescale 1ns/1ns
module trap_depth_check (
	trap_depth_if.chk dif // depth check signals
);
	// =====================================================
	// depth checks
	assign dif.overflow = dif.is_call && dif.enable && (dif.count == dif.max);
	assign dif.underflow = dif.is_ret && dif.enable && (dif.count == '0);
	assign dif.exception_return_depth_trap = dif.is_rfe && dif.enable && (dif.count != '0);
endmodule

// File: rtl/trap_detect.sv
// trap detection for protection, instruction error and context traps
// assumes all inputs synchronous to i_sys_clk; priority arbitration picks one class/ident pair here
// Operation
// - user-0 access to peripheral segment traps
// - load or store to address zero traps
// - global register write without permission traps
// - unknown opcode gives instruction error one
// - absent-unit instruction gives ident two
// - odd register pair operand gives ident three
// - misaligned data access gives ident four
// - bad circular buffer parameters give ident four
// - base plus offset changes segment traps
// - object spanning segment end traps
// - csfr, csa placement, scratch range trap
// - save into limit area then depletion trap
// - depletion during entry returns to handler
// - depletion sets sticky status flag
// - call at maximum depth traps
// - return at zero depth traps
// - save with null free head abandons
// - save or restore error also underflows
// - restore with null previous pointer traps
// - wrong saved context kind traps
// - exception return at nonzero depth traps
// - entry address is base or class shifted
// - ident number goes to data register fifteen
`timescale 1ns/1ns
module trap_detect (
	input wire logic i_sys_clk, // core clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic i_valid, // instruction in check stage
	input wire logic i_user0, // least privileged user level
	input wire logic i_mem_op, // instruction is load or store
	input wire logic i_seg_periph, // target segment is peripheral
	input wire logic [31:0] i_ea, // effective address
	input wire logic [31:0] i_base, // base address before offset
	input wire logic i_base_offset, // base plus offset mode
	input wire logic [3:0] i_acc_bytes, // access size in bytes
	input wire logic i_misaligned, // alignment rules violated
	input wire logic i_circ_bad, // circular buffer parameters bad
	input wire logic i_csfr_addr, // core register hit by memory address
	input wire logic i_csa_bad_place, // save area not allowed here
	input wire logic i_scratch_oor, // scratch access beyond memory
	input wire logic i_gw_write, // writes a global address register
	input wire logic i_gw_perm, // global write granted
	input wire logic i_opc_unknown, // opcode matches no instruction
	input wire logic i_opc_unimpl, // known but unit absent
	input wire logic i_opd_odd_pair, // odd register for pair operand
	input wire logic i_opd_check_en, // enables invalid operand trap
	input wire logic i_call, // call instruction
	input wire logic i_ret, // subroutine return
	input wire logic i_rfe, // exception return
	input wire logic i_cd_en, // call depth counting enabled
	input wire logic [6:0] i_cd_count, // call depth count
	input wire logic [6:0] i_cd_max, // call depth count maximum
	input wire logic i_save_req, // context save attempted
	input wire logic i_save_done, // context save completed
	input wire logic i_save_in_entry, // save belongs to trap or irq entry
	input wire logic [31:0] i_save_area, // area used by completed save
	input wire logic [31:0] i_limit_ptr, // context limit pointer
	input wire logic [31:0] i_free_head, // free list head pointer
	input wire logic i_ctx_err, // error during save or restore
	input wire logic i_restore_req, // context restore attempted
	input wire logic i_restore_upper, // restore is upper context
	input wire logic [31:0] i_prev_ptr, // previous context pointer
	input wire logic i_saved_kind, // saved context type bit
	input wire logic [31:0] i_handler_pc, // first instr of original handler
	input wire logic [31:0] i_next_pc, // next instr after the save
	input wire logic [31:0] i_vec_base, // vector table base
	input wire logic i_dsf_clear, // software clears status flag
	output logic o_trap_valid, // one trap pair presented
	output logic [2:0] o_trap_class_index, // class number
	output logic [7:0] o_trap_ident_number, // ident, for data reg 15
	output logic [31:0] o_entry_addr, // handler entry address
	output logic [7:0] o_cand_prot, // protection candidates by ident
	output logic [7:0] o_cand_instr, // instruction error candidates
	output logic [7:0] o_cand_ctx, // context candidates
	output logic o_depletion_status_flag, // sticky depletion flag
	output logic [31:0] o_ret_addr, // return address for depletion trap
	output logic o_ctx_abandon // abandon context op, drop async
);
	// =====================================================
	// state
	trap_detect_pkg::state_type st_reg;
	trap_detect_pkg::state_type st_next;
	trap_depth_if dif ();

	logic mem_ok;
	logic [31:0] last_byte;
	logic [7:0] prot_c;
	logic [7:0] instr_c;
	logic [7:0] ctx_c;

	assign dif.is_call = i_valid && i_call;
	assign dif.is_ret = i_valid && i_ret;
	assign dif.is_rfe = i_valid && i_rfe;
	assign dif.enable = i_cd_en;
	assign dif.count = i_cd_count;
	assign dif.max = i_cd_max;

	trap_depth_check u_depth (
		.dif(dif.chk)
	);

	// lowest set ident: older checks carry lower idents within a class
	function automatic logic [7:0] low_tin(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int k = 7; k >= 0; k--) begin
			if (v[k]) begin
				r = 8'(k);
			end
		end
		return r;
	endfunction

	// =====================================================
	// candidate detection
	always_comb begin
		mem_ok = i_valid && i_mem_op;
		// zero-size access is treated as one byte so the end never wraps below the start
		last_byte = i_ea + 32'(i_acc_bytes) - ((i_acc_bytes == 4'h0) ? 32'h0000_0000 : 32'h0000_0001);
		prot_c = 8'h00;
		instr_c = 8'h00;
		ctx_c = 8'h00;
		prot_c[trap_detect_pkg::TIN_PERIPH] = mem_ok && i_user0 && i_seg_periph;
		prot_c[trap_detect_pkg::TIN_NULL] = mem_ok && (i_ea == 32'h0000_0000);
		prot_c[trap_detect_pkg::TIN_GLOBAL] = i_valid && i_gw_write && !i_gw_perm;
		instr_c[trap_detect_pkg::TIN_ILLEGAL] = i_valid && i_opc_unknown;
		instr_c[trap_detect_pkg::TIN_UNIMPL] = i_valid && i_opc_unimpl;
		instr_c[trap_detect_pkg::TIN_OPERAND] = i_valid && i_opd_check_en && i_opd_odd_pair;
		instr_c[trap_detect_pkg::TIN_ALIGN] = mem_ok && (i_misaligned || i_circ_bad);
		// all three implementation constraints are raised by this core
		instr_c[trap_detect_pkg::TIN_MEMADDR] = mem_ok && ((i_base_offset && (i_ea[31:28] != i_base[31:28]))
			|| (last_byte[31:28] != i_ea[31:28])
			|| i_csfr_addr || i_csa_bad_place || i_scratch_oor);
		ctx_c[trap_detect_pkg::TIN_DEPLETE] = i_save_done && (i_save_area == i_limit_ptr);
		ctx_c[trap_detect_pkg::TIN_CDO] = dif.overflow;
		ctx_c[trap_detect_pkg::TIN_CDU] = dif.underflow;
		ctx_c[trap_detect_pkg::TIN_FREE_UNDER] = (i_save_req && (i_free_head == 32'h0000_0000))
			|| ((i_save_req || i_restore_req) && i_ctx_err);
		ctx_c[trap_detect_pkg::TIN_STACK_EMPTY] = i_restore_req && (i_prev_ptr == 32'h0000_0000);
		ctx_c[trap_detect_pkg::TIN_CTX_KIND] = i_restore_req && (i_restore_upper != i_saved_kind);
		ctx_c[trap_detect_pkg::TIN_EXCEPTION_RETURN_DEPTH_TRAP] = dif.exception_return_depth_trap;
	end

	// =====================================================
	// selection and next state
	always_comb begin
		st_next = st_reg;
		st_next.prot = prot_c;
		st_next.instr = instr_c;
		st_next.ctx = ctx_c;
		st_next.valid = (prot_c != 8'h00) || (instr_c != 8'h00) || (ctx_c != 8'h00);
		st_next.cls = 3'h0;
		st_next.trap_ident_number = 8'h00;
		// unrecoverable underflow wins, then format errors, so exactly one pair leaves
		if (ctx_c[trap_detect_pkg::TIN_FREE_UNDER]) begin
			st_next.cls = trap_detect_pkg::CLS_CTX;
			st_next.trap_ident_number = 8'(trap_detect_pkg::TIN_FREE_UNDER);
		end else if (instr_c[3:1] != 3'h0) begin
			st_next.cls = trap_detect_pkg::CLS_INSTR;
			st_next.trap_ident_number = instr_c[1] ? 8'(trap_detect_pkg::TIN_ILLEGAL)
				: (instr_c[3] ? 8'(trap_detect_pkg::TIN_OPERAND) : 8'(trap_detect_pkg::TIN_UNIMPL));
		end else if (prot_c != 8'h00) begin
			st_next.cls = trap_detect_pkg::CLS_PROT;
			st_next.trap_ident_number = low_tin(prot_c);
		end else if (instr_c != 8'h00) begin
			st_next.cls = trap_detect_pkg::CLS_INSTR;
			st_next.trap_ident_number = low_tin(instr_c);
		end else if (ctx_c != 8'h00) begin
			st_next.cls = trap_detect_pkg::CLS_CTX;
			st_next.trap_ident_number = low_tin(ctx_c);
		end
		st_next.entry = i_vec_base | (32'(st_next.cls) << trap_detect_pkg::TCN_SHIFT);
		// set beats clear when both land in one cycle
		st_next.dsf = (st_reg.dsf && !i_dsf_clear) || ctx_c[trap_detect_pkg::TIN_DEPLETE];
		st_next.ret_addr = i_save_in_entry ? i_handler_pc : i_next_pc;
		st_next.abandon = ctx_c[trap_detect_pkg::TIN_FREE_UNDER];
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// =====================================================
	// outputs
	assign o_trap_valid = st_reg.valid;
	assign o_trap_class_index = st_reg.cls;
	assign o_trap_ident_number = st_reg.trap_ident_number;
	assign o_entry_addr = st_reg.entry;
	assign o_cand_prot = st_reg.prot;
	assign o_cand_instr = st_reg.instr;
	assign o_cand_ctx = st_reg.ctx;
	assign o_depletion_status_flag = st_reg.dsf;
	assign o_ret_addr = st_reg.ret_addr;
	assign o_ctx_abandon = st_reg.abandon;

	// =====================================================
	// assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	periph_trap_a: assert property (i_valid && i_mem_op && i_user0 && i_seg_periph |=> o_cand_prot[5])
		else $error("peripheral access not flagged");
	null_addr_a: assert property (o_cand_prot[6] |-> $past(i_valid && i_mem_op && i_ea == 32'h0000_0000))
		else $error("null trap without null access");
	global_write_a: assert property (i_valid && i_gw_write && !i_gw_perm |=> o_cand_prot[7])
		else $error("global write trap missing");
	illegal_wins_a: assert property (i_valid && i_opc_unknown && !(i_save_req && i_free_head == 32'h0000_0000)
		&& !i_ctx_err |=> o_trap_class_index == 3'h2 && o_trap_ident_number == 8'h01)
		else $error("illegal opcode pair wrong");
	seg_cross_a: assert property (i_valid && i_mem_op && i_base_offset && i_ea[31:28] != i_base[31:28]
		|=> o_cand_instr[5])
		else $error("segment change not flagged");
	depletion_a: assert property (i_save_done && i_save_area == i_limit_ptr |=> o_cand_ctx[1] && o_depletion_status_flag)
		else $error("depletion flag not set");
	flag_holds_a: assert property (o_depletion_status_flag && !i_dsf_clear |=> o_depletion_status_flag)
		else $error("depletion flag lost");
	entry_ret_a: assert property (i_save_done && i_save_in_entry |=> o_ret_addr == $past(i_handler_pc))
		else $error("depletion return address wrong");
	underflow_a: assert property (i_save_req && i_free_head == 32'h0000_0000 |=> o_ctx_abandon
		&& o_trap_class_index == 3'h3 && o_trap_ident_number == 8'h04)
		else $error("free list underflow not taken");
	call_depth_a: assert property (i_valid && i_call && i_cd_en && i_cd_count == i_cd_max |=> o_cand_ctx[2])
		else $error("call depth overflow missing");
	exception_return_depth_trap_err_a: assert property (o_cand_ctx[7] |-> $past(i_rfe && i_cd_en && i_cd_count != 7'h00))
		else $error("nesting trap without cause");
	entry_addr_a: assert property (o_trap_valid |-> o_entry_addr == ($past(i_vec_base)
		| (32'(o_trap_class_index) << 5)))
		else $error("entry address wrong");
	one_pair_a: assert property (o_trap_valid |-> o_trap_class_index != 3'h0 && o_trap_ident_number != 8'h00)
		else $error("trap without pair");
	set_wins_a: assert property (i_save_done && i_save_area == i_limit_ptr && i_dsf_clear
		|=> o_depletion_status_flag)
		else $error("depletion flag lost to clear");
	kind_check_a: assert property (i_restore_req && i_restore_upper != i_saved_kind |=> o_cand_ctx[6])
		else $error("context kind trap missing");

	depletion_c: cover property (o_cand_ctx[1] && o_depletion_status_flag);
	multi_cand_c: cover property (o_cand_prot != 8'h00 && o_cand_instr != 8'h00);
	underflow_c: cover property (o_ctx_abandon);
	kind_err_c: cover property (o_cand_ctx[6]);
	exception_return_depth_trap_err_c: cover property (o_cand_ctx[7]);
endmodule
